// >>> rtl/bank_picker.sv
`timescale 1ns/1ns
`include "scp_defines.svh"

module bank_picker #(
  parameter logic [`SCP_BANK_W-1:0] BANK = 5'h00
) (
  // Request set and grant answer
  scp_req_if.picker bus
);

  // ****************************************
  // One-bank arbitration
  // ****************************************

  logic found;
  logic [`SCP_ENTRY_W-1:0] win;
  logic [`SCP_ENTRIES-1:0] grant_d;

  // Lowest pending entry on this bank wins; lane order is entry order
  always_comb begin
    found = 1'b0;
    win = '0;
    for (int e = 0; e < `SCP_ENTRIES; e++) begin
      if (!found && bus.pend[e] && bus.addr[e][`SCP_BANK_HI:`SCP_BANK_LO] == BANK) begin // R19
        found = 1'b1;
        win = e[`SCP_ENTRY_W-1:0];
      end
    end
  end

  // Winner plus reads of the identical word share one bank access
  always_comb begin
    grant_d = '0;
    for (int e = 0; e < `SCP_ENTRIES; e++) begin
      if (found && bus.pend[e] && bus.addr[e][`SCP_BANK_HI:`SCP_BANK_LO] == BANK) begin
        if (e[`SCP_ENTRY_W-1:0] == win) begin
          grant_d[e] = 1'b1; // R5
        end else if (!bus.wr &&
                     bus.addr[e][`SCP_ROW_HI:`SCP_BANK_LO] == bus.addr[win][`SCP_ROW_HI:`SCP_BANK_LO]) begin
          grant_d[e] = 1'b1; // R9
        end
      end
    end
  end

  assign bus.grant[BANK] = grant_d;
  assign bus.win_idx[BANK] = win;
  assign bus.win_ok[BANK] = found;

endmodule : bank_picker

// >>> rtl/banked_scratchpad_conflict_unit.sv
// How it works
// [R1] 64 kB per compute unit; one work-group addresses at most 32 kB.
// [R2] Storage is 32 banks, each one four-byte word wide.
// [R3] Byte address bits 6 down to 2 choose the bank.
// [R4] Lanes 0-31 and lanes 32-63 are checked separately, never against each other.
// [R5] Each bank serves at most one access per cycle; 32 distinct banks all go.
// [R6] Several accesses on one bank are served one per cycle on following cycles.
// [R7] Conflicts replay only still-waiting lanes until all are done; issue is not stalled. This block takes no beat while replaying.
// [R8] Completion takes as many cycles as the busiest bank has accesses.
// [R9] Reads of one identical address share one bank read, broadcast, no conflict.
// [R10] Requests from two issue beats, 32 lanes, are checked together.
// [R11] Each lane may present two four-byte requests per beat; all are accepted.
// [R12] Byte and halfword reads use a whole four-byte bank slot.
// [R13] Issuer starts reads with one operation launching two loads of up to four bytes.
// [R14] Issuer waits before using a result; the scratchpad never holds off issue. This block raises busy and ignores beats while replaying.
// [R15] Counters give busy time and time stalled by conflicts; zero without conflicts.
// [R16] Only kernel lanes reach the scratchpad; nothing host-side does.
// [R17] Contents stay until overwritten or the group ends; no tags, no fill.
// [R18] Lanes pass a barrier before reading values other lanes wrote.
// [R19] On each replay cycle the lowest-numbered pending lane of a bank goes first.
`timescale 1ns/1ns
`include "scp_defines.svh"

module banked_scratchpad_conflict_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Issue beat, sixteen lanes at a time
  input wire logic beat_valid,
  input wire logic beat_half,
  input wire logic op_write,
  input wire scp_pkg::size_type op_size,
  input wire logic [`SCP_ADDR_W-1:0] group_base,
  input wire logic [`SCP_BEAT_LANES-1:0] lane_en,
  input wire logic [`SCP_BEAT_LANES-1:0] lane_pair,
  input wire logic [`SCP_OFF_W-1:0] lane_off [`SCP_BEAT_LANES],
  input wire logic [`SCP_SLOTS*`SCP_WORD_W-1:0] lane_wdata [`SCP_BEAT_LANES],
  // Status
  output logic busy,
  output logic done,
  // Responses, one bit per lane slot
  output logic [`SCP_ENTRIES-1:0] rsp_valid,
  output logic rsp_half,
  output logic [`SCP_WORD_W-1:0] rsp_data [`SCP_ENTRIES],
  // Performance counters
  output logic [`SCP_CNT_W-1:0] busy_cycles,
  output logic [`SCP_CNT_W-1:0] conflict_stall_counter
);

  // ****************************************
  // Storage and state
  // ****************************************

  // Banked array; not reset, holds data across operations
  logic [`SCP_WORD_W-1:0] mem [`SCP_BANKS][`SCP_ROWS]; // R2 R17

  scp_pkg::state_type state_q;
  scp_pkg::state_type state_d;
  scp_pkg::size_type size_q;
  logic wr_q;
  logic half_q;
  logic first_q;
  logic done_q;
  logic [`SCP_ENTRIES-1:0] pend_q;
  logic [`SCP_ENTRIES-1:0] pend_d;
  logic [`SCP_ENTRIES-1:0] grant_all;
  logic [3:0] wmask [`SCP_BANKS];
  logic [`SCP_WORD_W-1:0] wword [`SCP_BANKS];
  logic [`SCP_ADDR_W-1:0] addr_q [`SCP_ENTRIES];
  logic [`SCP_WORD_W-1:0] wdata_q [`SCP_ENTRIES];
  logic [`SCP_ENTRIES-1:0] rsp_valid_q;
  logic rsp_half_q;
  logic [`SCP_WORD_W-1:0] rsp_data_q [`SCP_ENTRIES];
  logic [`SCP_CNT_W-1:0] busy_cnt_q;
  logic [`SCP_CNT_W-1:0] stall_cnt_q;
  logic run;
  logic take;
  logic base_sel;

  scp_req_if req ();

  // ****************************************
  // Helpers
  // ****************************************

  // Narrow reads still take a full word slot, then pick lanes
  function automatic logic [`SCP_WORD_W-1:0] pick_bytes(
    input logic [`SCP_WORD_W-1:0] word,
    input scp_pkg::size_type sz,
    input logic [1:0] off
  );
    logic [`SCP_WORD_W-1:0] sh;
    sh = word >> {off, 3'h0};
    case (sz)
      scp_pkg::SZ_BYTE: pick_bytes = {24'h000000, sh[7:0]}; // R12
      scp_pkg::SZ_HALF: pick_bytes = {16'h0000, sh[15:0]}; // R12
      default: pick_bytes = word;
    endcase
  endfunction : pick_bytes

  // Byte enables of a write
  function automatic logic [3:0] byte_mask(
    input scp_pkg::size_type sz,
    input logic [1:0] off
  );
    case (sz)
      scp_pkg::SZ_BYTE: byte_mask = 4'h1 << off;
      scp_pkg::SZ_HALF: byte_mask = off[1] ? 4'hc : 4'h3;
      default: byte_mask = 4'hf;
    endcase
  endfunction : byte_mask

  // Write data replicated onto every byte lane
  function automatic logic [`SCP_WORD_W-1:0] spread(
    input logic [`SCP_WORD_W-1:0] wd,
    input scp_pkg::size_type sz
  );
    case (sz)
      scp_pkg::SZ_BYTE: spread = {4{wd[7:0]}};
      scp_pkg::SZ_HALF: spread = {2{wd[15:0]}};
      default: spread = wd;
    endcase
  endfunction : spread

  // ****************************************
  // Conflict check, one picker per bank
  // ****************************************

  assign req.pend = run ? pend_q : '0;
  assign req.addr = addr_q;
  assign req.wr = wr_q;

  generate
    for (genvar b = 0; b < `SCP_BANKS; b++) begin : g_bank
      bank_picker #(
        .BANK(`SCP_BANK_W'(b))
      ) u_picker (
        .bus(req.picker)
      );
    end
  endgenerate

  // Banks own disjoint entries, so the union is the cycle's service set
  always_comb begin
    grant_all = '0;
    for (int b = 0; b < `SCP_BANKS; b++) begin
      grant_all = grant_all | req.grant[b]; // R5
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************

  assign run = (state_q == scp_pkg::ST_RUN);
  assign take = beat_valid && (state_q != scp_pkg::ST_RUN);
  assign base_sel = (state_q == scp_pkg::ST_FILL);

  // Two beats gather one half-wavefront, then replay until empty
  always_comb begin
    state_d = state_q;
    pend_d = pend_q & ~grant_all; // R6 R7
    case (state_q)
      scp_pkg::ST_IDLE: begin
        if (beat_valid) begin
          state_d = scp_pkg::ST_FILL;
        end
      end
      scp_pkg::ST_FILL: begin
        if (beat_valid) begin
          state_d = scp_pkg::ST_RUN; // R10
        end
      end
      scp_pkg::ST_RUN: begin
        if (pend_d == '0) begin
          state_d = scp_pkg::ST_IDLE; // R8
        end
      end
      default: begin
        state_d = scp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= scp_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Operation attributes latched from the first beat
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
      size_q <= scp_pkg::SZ_WORD;
      half_q <= 1'b0;
    end else if (beat_valid && state_q == scp_pkg::ST_IDLE) begin
      wr_q <= op_write;
      size_q <= op_size;
      half_q <= beat_half; // R4
    end
  end

  // ****************************************
  // Request capture
  // ****************************************

  // Pending mask: loaded per beat, cleared as entries are served
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= '0;
    end else if (run) begin
      pend_q <= pend_d; // R7
    end else if (take) begin
      for (int l = 0; l < `SCP_BEAT_LANES; l++) begin
        for (int s = 0; s < `SCP_SLOTS; s++) begin
          // Second slot only when the lane sends a pair
          pend_q[{base_sel, l[3:0], s[0]}] <= lane_en[l] && (s == 0 || lane_pair[l]); // R11 R13
        end
      end
    end
  end

  // Addresses and write data; offsets cannot leave the group window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int e = 0; e < `SCP_ENTRIES; e++) begin
        addr_q[e] <= '0;
        wdata_q[e] <= '0;
      end
    end else if (take) begin
      for (int l = 0; l < `SCP_BEAT_LANES; l++) begin
        for (int s = 0; s < `SCP_SLOTS; s++) begin
          addr_q[{base_sel, l[3:0], s[0]}] <= group_base + {1'b0, lane_off[l]} +
                                               (s == 0 ? '0 : `SCP_PAIR_STEP); // R1 R11
          wdata_q[{base_sel, l[3:0], s[0]}] <= lane_wdata[l][s*`SCP_WORD_W +: `SCP_WORD_W];
        end
      end
    end
  end

  // ****************************************
  // Bank access
  // ****************************************

  // Byte enables and lane data of each bank's winner; a call result cannot be bit-selected
  always_comb begin
    for (int b = 0; b < `SCP_BANKS; b++) begin
      wmask[b] = byte_mask(size_q, addr_q[req.win_idx[b]][1:0]);
      wword[b] = spread(wdata_q[req.win_idx[b]], size_q);
    end
  end

  // One write per bank per cycle, row from the bits above the bank field
  always_ff @(posedge clk) begin
    for (int b = 0; b < `SCP_BANKS; b++) begin
      if (run && wr_q && req.win_ok[b]) begin
        for (int k = 0; k < 4; k++) begin
          if (wmask[b][k]) begin
            mem[b][addr_q[req.win_idx[b]][`SCP_ROW_HI:`SCP_ROW_LO]][k*8 +: 8] <= wword[b][k*8 +: 8]; // R3 R5
          end
        end
      end
    end
  end

  // Read data per served entry; broadcast entries read the same word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int e = 0; e < `SCP_ENTRIES; e++) begin
        rsp_data_q[e] <= '0;
      end
    end else begin
      for (int e = 0; e < `SCP_ENTRIES; e++) begin
        if (run && !wr_q && grant_all[e]) begin
          rsp_data_q[e] <= pick_bytes(
            mem[addr_q[e][`SCP_BANK_HI:`SCP_BANK_LO]][addr_q[e][`SCP_ROW_HI:`SCP_ROW_LO]],
            size_q, addr_q[e][1:0]); // R3 R9 R12
        end
      end
    end
  end

  // Completion flags one cycle after service
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= '0;
      rsp_half_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      rsp_valid_q <= run ? grant_all : '0;
      rsp_half_q <= half_q;
      done_q <= run && (pend_d == '0); // R8
    end
  end

  // ****************************************
  // Performance counters
  // ****************************************

  // First run cycle is the normal pass; later ones are replays
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b0;
    end else begin
      first_q <= (state_q == scp_pkg::ST_FILL) && beat_valid;
    end
  end

  // Free-running, wrap at full scale; software forms the ratio
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_q <= '0;
      stall_cnt_q <= '0;
    end else begin
      if (state_q != scp_pkg::ST_IDLE) begin
        busy_cnt_q <= busy_cnt_q + 1'b1; // R15
      end
      if (run && !first_q) begin
        stall_cnt_q <= stall_cnt_q + 1'b1; // R15
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Busy only tells the issuer to wait; this block adds no other port
  assign busy = (state_q != scp_pkg::ST_IDLE); // R14 R16
  assign done = done_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_half = rsp_half_q;
  assign rsp_data = rsp_data_q;
  assign busy_cycles = busy_cnt_q;
  assign conflict_stall_counter = stall_cnt_q;

endmodule : banked_scratchpad_conflict_unit

// >>> rtl/scp_defines.svh
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ****************************************
// Geometry of the scratchpad
// ****************************************
`define SCP_TOTAL_BYTES 65536
`define SCP_GROUP_BYTES 32768
`define SCP_BANKS 32
`define SCP_BANK_W 5
`define SCP_ROWS 512
`define SCP_ROW_W 9
`define SCP_BANK_LO 2
`define SCP_BANK_HI 6
`define SCP_ROW_LO 7
`define SCP_ROW_HI 15
`define SCP_ADDR_W 16
`define SCP_OFF_W 15
`define SCP_PAIR_STEP 16'h0004

// ****************************************
// Lanes, beats and request entries
// ****************************************
`define SCP_HALF_LANES 32
`define SCP_BEAT_LANES 16
`define SCP_SLOTS 2
`define SCP_ENTRIES 64
`define SCP_ENTRY_W 6
`define SCP_WORD_W 32
`define SCP_CNT_W 32

`endif

// >>> rtl/scp_pkg.sv
package scp_pkg;

  // ****************************************
  // Types shared by the scratchpad files
  // ****************************************

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FILL = 3'h2,
    ST_RUN = 3'h4
  } state_type;

  // Access width of one request slot
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } size_type;

endpackage : scp_pkg

// >>> rtl/scp_req_if.sv
`timescale 1ns/1ns
`include "scp_defines.svh"

// ****************************************
// Pending requests and per-bank grants
// ****************************************
interface scp_req_if;
  logic [`SCP_ENTRIES-1:0] pend;
  logic [`SCP_ADDR_W-1:0] addr [`SCP_ENTRIES];
  logic wr;
  logic [`SCP_ENTRIES-1:0] grant [`SCP_BANKS];
  logic [`SCP_ENTRY_W-1:0] win_idx [`SCP_BANKS];
  logic win_ok [`SCP_BANKS];

  // Owner keeps the requests, pickers answer per bank
  modport owner (output pend, addr, wr, input grant, win_idx, win_ok);
  modport picker (input pend, addr, wr, output grant, win_idx, win_ok);
endinterface : scp_req_if

// >>> verif/banked_scratchpad_conflict_unit_tb.sv
`timescale 1ns/1ns

module banked_scratchpad_conflict_unit_tb;
  logic clk;
  logic sys_rst;
  logic beat_valid, beat_half, op_write, busy, done, rsp_half;
  scp_pkg::size_type op_size;
  logic [15:0] group_base, lane_en, lane_pair;
  logic [14:0] lane_off [16];
  logic [63:0] lane_wdata [16];
  logic [63:0] rsp_valid;
  logic [31:0] rsp_data [64];
  logic [31:0] busy_cycles, conflict_stall_counter;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  banked_scratchpad_conflict_unit banked_scratchpad_conflict_unit_i (.clk(clk), .sys_rst(sys_rst),
    .beat_valid(beat_valid), .beat_half(beat_half), .op_write(op_write), .op_size(op_size),
    .group_base(group_base), .lane_en(lane_en), .lane_pair(lane_pair), .lane_off(lane_off),
    .lane_wdata(lane_wdata), .busy(busy), .done(done), .rsp_valid(rsp_valid), .rsp_half(rsp_half),
    .rsp_data(rsp_data), .busy_cycles(busy_cycles), .conflict_stall_counter(conflict_stall_counter));

  lane_issuer lane_issuer_i (.clk(clk), .beat_valid(beat_valid), .beat_half(beat_half), .op_write(op_write),
    .op_size(op_size), .group_base(group_base), .lane_en(lane_en), .lane_pair(lane_pair),
    .lane_off(lane_off), .lane_wdata(lane_wdata));

  // Clock and hang guard; the whole sequence needs about a hundred cycles
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end

  // ****************************************
  // Compare and verdict
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // One operation with k accesses on its busiest bank
  task automatic run(input logic h, input logic w, input scp_pkg::size_type sz, input logic [15:0] base,
                     input logic [15:0] st, input logic [15:0] stp, input logic pr, input int k);
    logic [31:0] bc, sc, wv;
    logic [15:0] a;
    logic [63:0] seen, first;
    int n;
    bc = busy_cycles;
    sc = conflict_stall_counter;
    seen = '0;
    first = '0;
    n = 0;
    lane_issuer_i.issue(h, w, sz, base, st, stp, pr);
    while (n < 100) begin
      @(negedge clk);
      n++;
      seen |= rsp_valid;
      if (first == '0)
        first = rsp_valid;
      if (done === 1'b1)
        break;
    end
    chk("latency", 64'(k), 64'(n));
    chk("stall count", 64'(k - 1), 64'(conflict_stall_counter - sc));
    chk("busy count", 64'(k + 1), 64'(busy_cycles - bc));
    chk("rsp_half", 64'(h), 64'(rsp_half));
    if (!w) begin
      chk("first lane", 64'h1, 64'(first[0]));
      chk("rsp mask", pr ? '1 : {32{2'b01}}, seen);
      for (int e = 0; e < 64; e++) begin
        if (pr || !e[0]) begin
          a = base + st + 16'(e / 2) * stp + (e[0] ? 16'h0004 : 16'h0000);
          wv = lane_issuer_i.wd({a[15:2], 2'b00}) >> (8 * a[1:0]);
          if (sz == scp_pkg::SZ_BYTE)
            wv &= 32'h0000_00ff;
          if (sz == scp_pkg::SZ_HALF)
            wv &= 32'h0000_ffff;
          chk("rsp_data", 64'(wv), 64'(rsp_data[e]));
        end
      end
    end
  endtask : run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    chk("busy at reset", 64'h0, 64'(busy));
    chk("counter at reset", 64'h0, 64'(conflict_stall_counter));
    chk("busy count at reset", 64'h0, 64'(busy_cycles));
    // Pairs fill words 0-63, each bank twice
    run(1'b0, 1'b1, scp_pkg::SZ_WORD, 16'h0000, 16'h0000, 16'h0008, 1'b1, 2);
    run(1'b0, 1'b0, scp_pkg::SZ_WORD, 16'h0000, 16'h0000, 16'h0008, 1'b1, 2);
    // Upper half, 32 distinct banks in one cycle
    run(1'b1, 1'b0, scp_pkg::SZ_WORD, 16'h0000, 16'h0000, 16'h0004, 1'b0, 1);
    // All lanes on one bank, distinct rows
    run(1'b0, 1'b1, scp_pkg::SZ_WORD, 16'h4000, 16'h0000, 16'h0080, 1'b0, 32);
    run(1'b0, 1'b0, scp_pkg::SZ_WORD, 16'h4000, 16'h0000, 16'h0080, 1'b0, 32);
    // One shared word is broadcast
    run(1'b0, 1'b0, scp_pkg::SZ_WORD, 16'h0000, 16'h0010, 16'h0000, 1'b0, 1);
    // Narrow reads still take one bank slot each
    run(1'b0, 1'b0, scp_pkg::SZ_BYTE, 16'h0000, 16'h0001, 16'h0004, 1'b0, 1);
    run(1'b1, 1'b0, scp_pkg::SZ_HALF, 16'h0000, 16'h0002, 16'h0004, 1'b0, 1);
    print_verdict();
  end
endmodule : banked_scratchpad_conflict_unit_tb

// >>> verif/lane_issuer.sv
`timescale 1ns/1ns

// ****************************************
// Vector lanes issuing half-wavefronts
// ****************************************
module lane_issuer (
  // Clock
  input wire logic clk,
  // Issue beat
  output logic beat_valid,
  output logic beat_half,
  output logic op_write,
  output scp_pkg::size_type op_size,
  output logic [15:0] group_base,
  output logic [15:0] lane_en,
  output logic [15:0] lane_pair,
  output logic [14:0] lane_off [16],
  output logic [63:0] lane_wdata [16]
);
  // Stored word follows its address, so any stale read shows
  function automatic logic [31:0] wd(input logic [15:0] a);
    return {~a, a};
  endfunction : wd

  // Quiet lines at time zero
  initial begin
    beat_valid = 1'b0;
    beat_half = 1'b0;
    op_write = 1'b0;
    op_size = scp_pkg::SZ_WORD;
    group_base = 16'h0000;
    lane_en = 16'h0000;
    lane_pair = 16'h0000;
    lane_off = '{default: 15'h0000};
    lane_wdata = '{default: 64'h0};
  end

  // One operation, two back-to-back beats, two slots a lane when pr is set
  task automatic issue(input logic h, input logic w, input scp_pkg::size_type sz, input logic [15:0] base,
                       input logic [15:0] st, input logic [15:0] stp, input logic pr);
    logic [15:0] off;
    for (int b = 0; b < 2; b++) begin
      @(negedge clk);
      beat_valid = 1'b1;
      beat_half = h;
      op_write = w;
      op_size = sz;
      group_base = base;
      lane_en = 16'hffff;
      lane_pair = {16{pr}};
      for (int i = 0; i < 16; i++) begin
        off = st + 16'(b * 16 + i) * stp;
        lane_off[i] = off[14:0];
        lane_wdata[i] = {wd(base + off + 16'h0004), wd(base + off)};
      end
    end
    // Address, enable and data lines flip; beat_half, op_write, op_size and lane_pair keep the last value
    @(negedge clk);
    beat_valid = 1'b0;
    group_base = ~group_base;
    lane_en = ~lane_en;
    for (int i = 0; i < 16; i++) begin
      lane_off[i] = ~lane_off[i];
      lane_wdata[i] = ~lane_wdata[i];
    end
  endtask : issue
endmodule : lane_issuer

// >>> verif/scp_assertions.sv
`timescale 1ns/1ns

// ****************************************
// Checker on the top ports
// ****************************************
module scp_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Issue and status
  input wire logic beat_valid,
  input wire logic busy,
  input wire logic done,
  input wire logic [63:0] rsp_valid,
  // Counters
  input wire logic [31:0] busy_cycles,
  input wire logic [31:0] conflict_stall_counter
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Status and completion timing
  a_done_not_busy: assert property (done |-> !busy)
    else $error("busy high in done cycle");
  a_busy_after_beats: assert property ((beat_valid && !busy) ##1 beat_valid |=> busy)
    else $error("busy not raised after two beats");
  a_first_answer: assert property ((beat_valid && !busy) ##1 beat_valid |-> ##2 (rsp_valid != '0 || done))
    else $error("no answer two cycles after second beat");
  a_done_bound: assert property ((beat_valid && !busy) ##1 beat_valid |-> ##[2:65] done)
    else $error("operation ran past worst bank count");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_rsp_after_run: assert property (rsp_valid != '0 |-> $past(busy))
    else $error("response without a running cycle");
  // Counters only move while busy
  a_idle_no_stall: assert property (!busy |=> $stable(conflict_stall_counter))
    else $error("stall count moved while idle");
  a_busy_counts: assert property (busy |=> busy_cycles == $past(busy_cycles) + 32'h1)
    else $error("busy count missed a cycle");
  a_stall_in_run: assert property ($changed(conflict_stall_counter) |-> $past(busy) && $past(busy, 2))
    else $error("stall counted outside a replay");
endmodule : scp_assertions

bind banked_scratchpad_conflict_unit scp_assertions scp_assertions_i (.clk(clk), .sys_rst(sys_rst),
  .beat_valid(beat_valid), .busy(busy), .done(done), .rsp_valid(rsp_valid), .busy_cycles(busy_cycles),
  .conflict_stall_counter(conflict_stall_counter));
